// >>> adcorc_crc16.sv
// Bit serial CRC-16 engine, one stream bit per clock
`timescale 1ns/10ps
`default_nettype none
`include "adcorc_regs.svh"

module adcorc_crc16 #(
    parameter int NBITS = `ADCORC_CRC_STEPS
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    input  wire logic             i_start,
    input  wire logic [NBITS-1:0] i_stream,
    output logic                  o_done,
    output logic [15:0]           o_crc
);
    import adcorc_pkg::*;

    localparam logic [15:0] POLY = `ADCORC_CRC_POLY;

    adcorc_crc_state_t state_q;
    adcorc_crc_state_t state_d;
    logic [15:0]       lfsr_q;
    logic [15:0]       lfsr_d;
    logic [NBITS-1:0]  sh_q;
    logic [NBITS-1:0]  sh_d;
    logic [6:0]        step_q;
    logic [6:0]        step_d;
    logic [15:0]       crc_q;
    logic              feedback;
    logic [15:0]       lfsr_next;
    logic              last_step;

    assign feedback  = sh_q[0] ^ lfsr_q[15];
    assign last_step = (step_q == 7'(NBITS - 1));

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_tap
            if (gi == 0)
            begin : g_b0
                assign lfsr_next[gi] = feedback & POLY[gi];
            end
            else
            begin : g_bi
                assign lfsr_next[gi] = (feedback & POLY[gi]) ^ lfsr_q[gi-1];
            end
        end
    endgenerate

    always_comb
    begin
        state_d = state_q;
        lfsr_d  = lfsr_q;
        sh_d    = sh_q;
        step_d  = step_q;
        unique case (state_q)
            ADCORC_CRC_IDLE:
            begin
                if (i_start)
                begin
                    lfsr_d  = `ADCORC_CRC_PRESET;
                    sh_d    = i_stream;
                    step_d  = '0;
                    state_d = ADCORC_CRC_RUN;
                end
            end
            ADCORC_CRC_RUN:
            begin
                lfsr_d = lfsr_next;
                sh_d   = sh_q >> 1;
                step_d = step_q + 7'd1;
                if (last_step)
                    state_d = ADCORC_CRC_DONE;
            end
            ADCORC_CRC_DONE:
            begin
                state_d = ADCORC_CRC_IDLE;
            end
            default:
            begin
                state_d = ADCORC_CRC_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_q <= ADCORC_CRC_IDLE;
            lfsr_q  <= `ADCORC_CRC_PRESET;
            sh_q    <= '0;
            step_q  <= '0;
            crc_q   <= '0;
        end
        else
        begin
            state_q <= state_d;
            lfsr_q  <= lfsr_d;
            sh_q    <= sh_d;
            step_q  <= step_d;
            if (state_q == ADCORC_CRC_DONE)
                crc_q <= lfsr_q;
        end
    end

    assign o_done = (state_q == ADCORC_CRC_DONE);
    assign o_crc  = crc_q;
endmodule : adcorc_crc16
`default_nettype wire

// >>> adcorc_host_model.sv
// Host side model: register reads and writes, settle wait
`timescale 1ns/10ps
`default_nettype none

module adcorc_host_model #(
    parameter int SETTLE_CYC = 500000
) (
    input  wire logic        i_clk_sys,
    input  wire logic [23:0] i_reg_rdata,
    output logic             o_reg_wr,
    output logic [7:0]       o_reg_wdata,
    output logic             o_reg_rd,
    output logic [3:0]       o_reg_addr
);
    // ------------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------------
    // Idle address shows the inverse of the last one; write data is inverted only after a write, a read leaves it as it was
    initial
    begin
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
        o_reg_wdata = 8'h00;
        o_reg_addr  = 4'hf;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_reg_wr    = 1'b1;
        o_reg_addr  = a;
        o_reg_wdata = d;
        @(negedge i_clk_sys);
        o_reg_wr    = 1'b0;
        o_reg_addr  = ~a;
        o_reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [23:0] d);
        @(negedge i_clk_sys);
        o_reg_rd   = 1'b1;
        o_reg_addr = a;
        @(negedge i_clk_sys);
        o_reg_rd   = 1'b0;
        o_reg_addr = ~a;
        d          = i_reg_rdata;
    endtask : rd

    task automatic settle();
        repeat (SETTLE_CYC) @(negedge i_clk_sys);
    endtask : settle
endmodule : adcorc_host_model

`default_nettype wire

// >>> adcorc_pkg.sv
// Types shared by the converter back end
package adcorc_pkg;

    typedef struct packed {
        logic [23:0] current;
        logic [23:0] voltage1;
        logic [23:0] voltage2;
    } adcorc_results_t;

    typedef struct packed {
        logic       bandwidth_select;
        logic [1:0] output_rate_select;
        logic       temp_sense_select;
    } adcorc_setup_t;

    typedef enum logic [1:0] {
        ADCORC_CRC_IDLE = 2'b00,
        ADCORC_CRC_RUN  = 2'b01,
        ADCORC_CRC_DONE = 2'b10
    } adcorc_crc_state_t;

endpackage : adcorc_pkg

// >>> adcorc_rate_gen.sv
// Output cycle and modulator sample strobe generator
`timescale 1ns/10ps
`default_nettype none
`include "adcorc_regs.svh"

module adcorc_rate_gen #(
    parameter int CNT_W = 12
) (
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    input  wire logic [1:0] i_rate_sel,
    output logic            o_mod_strobe,
    output logic            o_cycle_strobe
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] last_count;
    logic [CNT_W-1:0] mod_mask;

    // Period is 512 << rate_sel input clocks
    assign last_count = CNT_W'((32'd1 << (`ADCORC_BASE_DIV_LOG2 + 32'(i_rate_sel))) - 32'd1);
    assign mod_mask   = CNT_W'(`ADCORC_MOD_DIV - 1);
    // Late rate change wraps at the next sample, keeping the beat
    assign o_cycle_strobe = (cnt_q >= last_count) && o_mod_strobe;
    assign o_mod_strobe   = ((cnt_q & mod_mask) == mod_mask);
    assign cnt_d = o_cycle_strobe ? '0 : cnt_q + CNT_W'(1);

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end
endmodule : adcorc_rate_gen
`default_nettype wire

// >>> adcorc_regs.svh
// Register map, field positions and timing constants for the converter back end
`ifndef ADCORC_REGS_SVH
`define ADCORC_REGS_SVH

// ----------------------------------------------------------------------------
// Register addresses (read port index)
// ----------------------------------------------------------------------------
`define ADCORC_ADDR_CURRENT_WAVE  4'h0
`define ADCORC_ADDR_VOLTAGE1_WAVE 4'h1
`define ADCORC_ADDR_VOLTAGE2_WAVE 4'h2
`define ADCORC_ADDR_OUTPUT_CRC    4'h3
`define ADCORC_ADDR_TEMP_OFFSET   4'h4
`define ADCORC_ADDR_SETUP         4'h5
`define ADCORC_ADDR_STATUS_ONE    4'h6

// ----------------------------------------------------------------------------
// Setup register fields and reset, status not-read bit
// ----------------------------------------------------------------------------
`define ADCORC_SETUP_TEMP_BIT     3
`define ADCORC_SETUP_RATE_LO      4
`define ADCORC_SETUP_RATE_HI      5
`define ADCORC_SETUP_BW_BIT       7
`define ADCORC_SETUP_RESET        8'h00
`define ADCORC_STATUS_NREAD_BIT   3

// ----------------------------------------------------------------------------
// Rates and CRC
// ----------------------------------------------------------------------------
`define ADCORC_MOD_DIV            4
`define ADCORC_BASE_DIV_LOG2      9
`define ADCORC_CRC_PRESET         16'hffff
`define ADCORC_CRC_POLY           16'h1021
`define ADCORC_CRC_STEPS          72
`define ADCORC_RESULT_MAX         24'h7fffff
`define ADCORC_RESULT_MIN         24'h800000

`endif

// >>> adcorc_top.sv
// Converter back end: output rate, result capture, result CRC, temperature mux
// Contract
// - One result set per 512, 1024, 2048 or 4096 input clocks by rate select.
// - Bandwidth select at setup bit 7, default wide, set narrows the filter.
// - Results are 24-bit two's complement, clamped to 0x800000..0x7fffff.
// - Current, voltage1, voltage2 each held in own 24-bit register per cycle.
// - CRC over the three results recomputed once per output cycle.
// - CRC stream takes each result least significant byte first, bits MSB first.
// - First stream bit is current bit 7, last is voltage2 bit 16.
// - CRC state preset to all ones before the first stream bit.
// - Polynomial x16 + x12 + x5 + 1.
// - Feedback is stream bit xor b15; bits shift up with tap xor.
// - After step 72 the state is stored as output_crc.
// - output_crc readable singly and within a burst.
// - Temp select at setup bit 3 routes temperature sensor into voltage2.
// - temp_offset is a signed 8-bit read-only trimmed offset.
// - Modulators sample at input clock divided by four.
// - Unread results in a cycle set output_not_read; status read clears it.
`timescale 1ns/10ps
`default_nettype none
`include "adcorc_regs.svh"

module adcorc_top #(
    parameter logic [7:0] TEMP_OFFSET_TRIM = 8'h00
) (
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_rst_n,
    // Filter results from the decimators, one per channel
    input  wire adcorc_pkg::adcorc_results_t i_filt,
    input  wire logic [23:0]                i_temp_filt,
    // Register port: write setup, read any register
    input  wire logic                       i_reg_wr,
    input  wire logic [7:0]                 i_reg_wdata,
    input  wire logic                       i_reg_rd,
    input  wire logic [3:0]                 i_reg_addr,
    output logic [23:0]                     o_reg_rdata,
    // Analog side controls, plus cycle strobe and not-read flag
    output logic                            o_mod_strobe,
    output logic                            o_temp_sense_select,
    output logic                            o_bandwidth_select,
    output logic [1:0]                      o_output_rate_select,
    output logic                            o_cycle_strobe,
    output logic                            o_output_not_read
);
    import adcorc_pkg::*;

    // ------------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic       rst_n;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rst_sync_q <= 2'b00;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------------------
    // Setup register
    // ------------------------------------------------------------------------
    logic [7:0]    setup_q;
    adcorc_setup_t setup;

    assign setup.bandwidth_select   = setup_q[`ADCORC_SETUP_BW_BIT];
    assign setup.output_rate_select = setup_q[`ADCORC_SETUP_RATE_HI:`ADCORC_SETUP_RATE_LO];
    assign setup.temp_sense_select  = setup_q[`ADCORC_SETUP_TEMP_BIT];

    logic wr_setup;
    assign wr_setup = i_reg_wr && (i_reg_addr == `ADCORC_ADDR_SETUP);

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            setup_q <= `ADCORC_SETUP_RESET;
        else if (wr_setup)
            setup_q <= i_reg_wdata;
    end

    assign o_bandwidth_select   = setup.bandwidth_select;
    assign o_output_rate_select = setup.output_rate_select;
    // Sensor settling takes 5 ms; the host waits, no gating here
    assign o_temp_sense_select  = setup.temp_sense_select;

    // ------------------------------------------------------------------------
    // Output rate and modulator strobe
    // ------------------------------------------------------------------------
    logic cycle;

    adcorc_rate_gen #(
        .CNT_W (12)
    ) u_rate (
        .i_clk_sys      (i_clk_sys),
        .i_rst_n        (rst_n),
        .i_rate_sel     (setup.output_rate_select),
        .o_mod_strobe   (o_mod_strobe),
        .o_cycle_strobe (cycle)
    );
    assign o_cycle_strobe = cycle;

    // ------------------------------------------------------------------------
    // Result capture with saturation
    // ------------------------------------------------------------------------
    function automatic logic [23:0] adcorc_clamp(input logic [23:0] v);
        // No-op for in-span codes; pins the span
        logic signed [23:0] s;
        s = signed'(v);
        if (s > signed'(`ADCORC_RESULT_MAX))
            adcorc_clamp = `ADCORC_RESULT_MAX;
        else if (s < signed'(`ADCORC_RESULT_MIN))
            adcorc_clamp = `ADCORC_RESULT_MIN;
        else
            adcorc_clamp = v;
    endfunction : adcorc_clamp

    adcorc_results_t cap_q;
    adcorc_results_t shown_q;
    logic [23:0]     ch3_src;

    assign ch3_src = setup.temp_sense_select ? i_temp_filt : i_filt.voltage2;

    // Capture at cycle edge, publish once the CRC over the same set is done
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            cap_q <= '0;
        else if (cycle)
        begin
            cap_q.current  <= adcorc_clamp(i_filt.current);
            cap_q.voltage1 <= adcorc_clamp(i_filt.voltage1);
            cap_q.voltage2 <= adcorc_clamp(ch3_src);
        end
    end

    // ------------------------------------------------------------------------
    // Result CRC
    // ------------------------------------------------------------------------
    logic [`ADCORC_CRC_STEPS-1:0] stream;
    logic                         crc_start_q;
    logic                         crc_done;
    logic [15:0]                  crc_val;

    // Stream index 0 enters first: per register bytes LSB first, bits MSB first
    genvar gb;
    generate
        for (gb = 0; gb < `ADCORC_CRC_STEPS; gb++)
        begin : g_stream
            localparam int REG  = gb / 24;
            localparam int BYTE = (gb % 24) / 8;
            localparam int BIT  = 7 - (gb % 8);
            localparam int POS  = (2 - REG) * 24 + BYTE * 8 + BIT;
            assign stream[gb] = cap_q[POS];
        end
    endgenerate

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            crc_start_q <= 1'b0;
        else
            crc_start_q <= cycle;
    end

    adcorc_crc16 #(
        .NBITS (`ADCORC_CRC_STEPS)
    ) u_crc (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (rst_n),
        .i_start   (crc_start_q),
        .i_stream  (stream),
        .o_done    (crc_done),
        .o_crc     (crc_val)
    );

    // ------------------------------------------------------------------------
    // Published results and CRC, switched in one edge
    // ------------------------------------------------------------------------
    logic [15:0] crc_shown_q;
    logic        publish_q;

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            publish_q <= 1'b0;
        else
            publish_q <= crc_done;
    end

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            shown_q     <= '0;
            crc_shown_q <= `ADCORC_CRC_PRESET;
        end
        else if (publish_q)
        begin
            shown_q     <= cap_q;
            crc_shown_q <= crc_val;
        end
    end

    // ------------------------------------------------------------------------
    // Read tracking and not-read flag
    // ------------------------------------------------------------------------
    logic [2:0] read_seen_q;
    logic [2:0] read_hit;
    logic       not_read_q;
    logic       status_rd;
    logic       missed;

    assign read_hit[0] = i_reg_rd && (i_reg_addr == `ADCORC_ADDR_CURRENT_WAVE);
    assign read_hit[1] = i_reg_rd && (i_reg_addr == `ADCORC_ADDR_VOLTAGE1_WAVE);
    assign read_hit[2] = i_reg_rd && (i_reg_addr == `ADCORC_ADDR_VOLTAGE2_WAVE);
    assign status_rd   = i_reg_rd && (i_reg_addr == `ADCORC_ADDR_STATUS_ONE);
    // Missed if any result was left unread when the next set is published
    assign missed      = publish_q && ((read_seen_q | read_hit) != 3'b111);

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            read_seen_q <= 3'b111;
        else if (publish_q)
            read_seen_q <= 3'b000;
        else
            read_seen_q <= read_seen_q | read_hit;
    end

    // Set wins over a clearing status read in the same cycle
    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            not_read_q <= 1'b0;
        else if (missed)
            not_read_q <= 1'b1;
        else if (status_rd)
            not_read_q <= 1'b0;
    end
    assign o_output_not_read = not_read_q;

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    logic [23:0] rd_mux;
    logic [7:0]  status_word;
    logic [7:0]  temp_offset;

    assign temp_offset = TEMP_OFFSET_TRIM;
    assign status_word = 8'(not_read_q) << `ADCORC_STATUS_NREAD_BIT;

    always_comb
    begin
        rd_mux = '0;
        unique case (i_reg_addr)
            `ADCORC_ADDR_CURRENT_WAVE:  rd_mux = shown_q.current;
            `ADCORC_ADDR_VOLTAGE1_WAVE: rd_mux = shown_q.voltage1;
            `ADCORC_ADDR_VOLTAGE2_WAVE: rd_mux = shown_q.voltage2;
            `ADCORC_ADDR_OUTPUT_CRC:    rd_mux = {8'h00, crc_shown_q};
            `ADCORC_ADDR_TEMP_OFFSET:   rd_mux = {16'h0000, temp_offset};
            `ADCORC_ADDR_SETUP:         rd_mux = {16'h0000, setup_q};
            `ADCORC_ADDR_STATUS_ONE:    rd_mux = {16'h0000, status_word};
            default:                    rd_mux = '0;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            o_reg_rdata <= '0;
        else if (i_reg_rd)
            o_reg_rdata <= rd_mux;
    end
endmodule : adcorc_top
`default_nettype wire

// >>> adcorc_top_sva.sv
// Port checker for the converter back end, bound to the top module
`timescale 1ns/10ps
`default_nettype none

module adcorc_top_sva #(
    parameter logic [7:0] TEMP_OFFSET_TRIM = 8'h00
) (
    input wire logic        i_clk_sys,
    input wire logic        i_rst_n,
    input wire logic        i_reg_wr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic        i_reg_rd,
    input wire logic [3:0]  i_reg_addr,
    input wire logic [23:0] o_reg_rdata,
    input wire logic        o_mod_strobe,
    input wire logic        o_temp_sense_select,
    input wire logic        o_bandwidth_select,
    input wire logic [1:0]  o_output_rate_select,
    input wire logic        o_cycle_strobe,
    input wire logic        o_output_not_read
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    // ------------------------------------------------------------------------
    // Helpers: cycles since strobe, rate change, reset age
    // ------------------------------------------------------------------------
    // Inner reset lags the pin two edges; wait it out
    logic [12:0] since_q;
    logic        seen_q;
    logic        chg_q;
    logic [1:0]  rate_q;
    logic [1:0]  up_q;
    wire         up_ok = (up_q == 2'h3);
    wire         set_wr = up_ok && i_reg_wr && i_reg_addr == 4'h5;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            since_q <= 13'h0;
            seen_q  <= 1'b0;
            chg_q   <= 1'b0;
            rate_q  <= 2'h0;
            up_q    <= 2'h0;
        end
        else
        begin
            since_q <= o_cycle_strobe ? 13'h0 : since_q + 13'h1;
            seen_q  <= seen_q | o_cycle_strobe;
            chg_q   <= o_cycle_strobe ? 1'b0 : (chg_q | (rate_q != o_output_rate_select));
            rate_q  <= o_output_rate_select;
            up_q    <= up_q + {1'b0, !up_ok};
        end
    end

    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    property p_mod_rate;
        up_ok && o_mod_strobe |=> !o_mod_strobe [*3] ##1 o_mod_strobe;
    endproperty
    a_mod_rate: assert property (p_mod_rate) else $error("mod strobe gap");

    property p_cycle_period;
        o_cycle_strobe && seen_q && !chg_q && rate_q == o_output_rate_select
            |-> since_q == (13'd512 << o_output_rate_select) - 13'd1;
    endproperty
    a_cycle_period: assert property (p_cycle_period) else $error("cycle period");

    property p_rate_wr;
        set_wr |=> o_output_rate_select == $past(i_reg_wdata[5:4]);
    endproperty
    a_rate_wr: assert property (p_rate_wr) else $error("rate write");

    property p_bw_wr;
        set_wr |=> o_bandwidth_select == $past(i_reg_wdata[7]);
    endproperty
    a_bw_wr: assert property (p_bw_wr) else $error("bandwidth write");

    property p_temp_wr;
        set_wr |=> o_temp_sense_select == $past(i_reg_wdata[3]);
    endproperty
    a_temp_wr: assert property (p_temp_wr) else $error("temp select write");

    property p_toff_rd;
        i_reg_rd && i_reg_addr == 4'h4 |=> o_reg_rdata[7:0] == TEMP_OFFSET_TRIM;
    endproperty
    a_toff_rd: assert property (p_toff_rd) else $error("temp offset read");

    property p_rdata_hold;
        !i_reg_rd |=> $stable(o_reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

    property p_status_rd;
        i_reg_rd && i_reg_addr == 4'h6 |=> o_reg_rdata[3] == $past(o_output_not_read);
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("status read data");

    property p_nr_rise;
        $rose(o_output_not_read) |-> seen_q && since_q inside {[13'd70:13'd80]};
    endproperty
    a_nr_rise: assert property (p_nr_rise) else $error("unread rise timing");

    property p_nr_clear;
        seen_q && i_reg_rd && i_reg_addr == 4'h6 && (since_q < 13'd60 || since_q > 13'd76) |=> !o_output_not_read;
    endproperty
    a_nr_clear: assert property (p_nr_clear) else $error("unread flag not cleared");
endmodule : adcorc_top_sva

bind adcorc_top adcorc_top_sva #(.TEMP_OFFSET_TRIM(TEMP_OFFSET_TRIM)) u_sva (
    .i_clk_sys           (i_clk_sys),
    .i_rst_n             (i_rst_n),
    .i_reg_wr            (i_reg_wr),
    .i_reg_wdata         (i_reg_wdata),
    .i_reg_rd            (i_reg_rd),
    .i_reg_addr          (i_reg_addr),
    .o_reg_rdata         (o_reg_rdata),
    .o_mod_strobe        (o_mod_strobe),
    .o_temp_sense_select (o_temp_sense_select),
    .o_bandwidth_select  (o_bandwidth_select),
    .o_output_rate_select(o_output_rate_select),
    .o_cycle_strobe      (o_cycle_strobe),
    .o_output_not_read   (o_output_not_read)
);

`default_nettype wire

// >>> tb.sv
// Self-checking testbench for the converter back end
`timescale 1ns/10ps
`default_nettype none

module tb;
    import adcorc_pkg::*;
    // Negative trim shows the sign
    localparam logic [7:0] TRIM = 8'hf6;

    logic            i_clk_sys = 1'b0, i_rst_n = 1'b0;
    adcorc_results_t filt, rv;
    logic [23:0]     temp_filt, rdata, d;
    logic            wr, rd, mod_s, temp_s, bw_s, cyc_s, nr;
    logic [7:0]      wdata;
    logic [3:0]      addr;
    logic [1:0]      rate_s;
    int              num_errors = 0, comparisons = 0, n;
    adcorc_results_t vec [3] = '{'{24'h123456, 24'habcdef, 24'h0f1e2d},
                                 '{24'h7fffff, 24'h800000, 24'h000001},
                                 '{24'h000000, 24'hffffff, 24'h5a5a5a}};

    always #5 i_clk_sys = ~i_clk_sys;

    adcorc_top #(.TEMP_OFFSET_TRIM(TRIM)) u_dut (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_filt(filt), .i_temp_filt(temp_filt),
        .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .i_reg_addr(addr), .o_reg_rdata(rdata),
        .o_mod_strobe(mod_s), .o_temp_sense_select(temp_s), .o_bandwidth_select(bw_s),
        .o_output_rate_select(rate_s), .o_cycle_strobe(cyc_s), .o_output_not_read(nr));

    adcorc_host_model #(.SETTLE_CYC(600)) u_host (
        .i_clk_sys(i_clk_sys), .i_reg_rdata(rdata), .o_reg_wr(wr), .o_reg_wdata(wdata),
        .o_reg_rd(rd), .o_reg_addr(addr));

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    function automatic logic [15:0] crc_ref(input adcorc_results_t r);
        logic [71:0] w;
        logic [15:0] b;
        logic        fb;
        w = {r.voltage2, r.voltage1, r.current};
        b = 16'hffff;
        for (int k = 0; k < 9; k++)
            for (int i = 7; i >= 0; i--)
            begin
                fb = w[8*k+i] ^ b[15];
                b  = {b[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
            end
        return b;
    endfunction : crc_ref

    // Negedges to the next strobe, bounded
    task automatic wait_cyc(output int k);
        k = 0;
        do
        begin
            @(negedge i_clk_sys);
            k++;
        end while (cyc_s !== 1'b1 && k < 9000);
        if (k >= 9000)
            chk("cycle_strobe", 24'h1, 24'h0);
    endtask : wait_cyc

    task automatic publish();
        wait_cyc(n);
        repeat (80) @(negedge i_clk_sys);
    endtask : publish

    task automatic burst(input adcorc_results_t r);
        logic [23:0] x;
        u_host.rd(4'h0, x);
        chk("current_wave", r.current, x);
        u_host.rd(4'h1, x);
        chk("voltage1_wave", r.voltage1, x);
        u_host.rd(4'h2, x);
        chk("voltage2_wave", r.voltage2, x);
        u_host.rd(4'h3, x);
        chk("output_crc", {8'h00, crc_ref(r)}, x);
    endtask : burst

    // ------------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------------
    initial
    begin
        filt      = vec[0];
        temp_filt = 24'hc0ffee;
        repeat (8) @(negedge i_clk_sys);
        i_rst_n = 1'b1;
        repeat (3) @(negedge i_clk_sys);
        u_host.rd(4'h5, d);
        chk("setup", 24'h0, d);
        chk("bandwidth_select", 24'h0, {23'h0, bw_s});
        chk("temp_sense_select", 24'h0, {23'h0, temp_s});
        u_host.wr(4'h4, 8'h00);
        u_host.rd(4'h4, d);
        chk("temp_offset", {16'h0, TRIM}, d);
        u_host.wr(4'h0, 8'h55);
        u_host.rd(4'h7, d);
        chk("unmapped", 24'h0, d);
        for (int r = 0; r < 4; r++)
        begin
            u_host.wr(4'h5, {2'b00, r[1:0], 4'h0});
            wait_cyc(n);
            wait_cyc(n);
            chk("period", 24'(512 << r), 24'(n));
            chk("output_rate_select", 24'(r), {22'h0, rate_s});
        end
        u_host.wr(4'h5, 8'h80);
        u_host.rd(4'h5, d);
        chk("setup_bw", 24'h80, d);
        chk("bandwidth_select", 24'h1, {23'h0, bw_s});
        u_host.wr(4'h5, 8'h00);
        foreach (vec[i])
        begin
            filt = vec[i];
            publish();
            burst(vec[i]);
        end
        u_host.wr(4'h5, 8'h08);
        chk("temp_sense_select", 24'h1, {23'h0, temp_s});
        u_host.settle();
        publish();
        rv          = filt;
        rv.voltage2 = temp_filt;
        burst(rv);
        u_host.wr(4'h5, 8'h00);
        publish();
        u_host.rd(4'h6, d);
        burst(filt);
        publish();
        u_host.rd(4'h6, d);
        chk("not_read_clear", 24'h0, d & 24'h8);
        publish();
        chk("not_read_flag", 24'h1, {23'h0, nr});
        u_host.rd(4'h6, d);
        chk("not_read_set", 24'h8, d & 24'h8);
        u_host.rd(4'h6, d);
        chk("not_read_cleared", 24'h0, d & 24'h8);
        tally_and_finish();
    end

    initial
    begin
        repeat (60000) @(posedge i_clk_sys);
        num_errors++;
        $display("BAD watchdog expected done seen timeout");
        tally_and_finish();
    end
endmodule : tb

`default_nettype wire
